// File: hdl/adc_sel_cfg.svh
/*
 * Offsets, field positions, reset values and timing figures of the converter
 * control block. Assumes inclusion by bare name from adc_resolution_channel_select only.
 */
`ifndef ADC_SEL_CFG_SVH
`define ADC_SEL_CFG_SVH
// Register byte offsets on the AXI4-Lite port.
`define OFF_CTRL 8'h00
`define OFF_UPPER 8'h04
`define OFF_CH0 8'h08
`define OFF_SCAN 8'h0c
`define OFF_SHARE 8'h10
`define OFF_STAT 8'h14
`define OFF_AVAIL 8'h18
`define OFF_RES_BASE 4'h2
// Control register field positions.
`define CTRL_ON 0
`define CTRL_RES12 1
`define CTRL_FMT 2
`define CTRL_TRIG 4
`define CTRL_SCAN 6
`define CTRL_SIMUL 7
`define CTRL_PTG 8
`define CTRL_SWTRIG 9
// Sharing register field positions.
`define SHARE_OPAMP 0
`define SHARE_CMP 4
`define SHARE_VREF 8
// Reset values.
`define RST_CH0 4'h0
`define RST_SCAN 16'h0000
// Pins taken by the external voltage reference when it is enabled.
`define VREF_PINS 16'h0003
// Clock rate and conversion rate ceilings.
`define CLK_KHZ 200000
`define RATE10_KSPS 1100
`define RATE12_KSPS 500
`endif

// File: hdl/adc_sel_pkg.sv
/*
 * Types shared by the converter control block and its helpers.
 * Assumes the constants header is on the include path.
 */
package adc_sel_pkg;
    // Source of one upper sampling channel: op amp output or analog pin.
    typedef struct packed {logic opamp; logic [3:0] idx;} src_t;
    // Conversion sequencer states.
    typedef enum logic {IDLE, BUSY} conv_state_t;
    // Trigger sources; the fourth code is illegal.
    typedef enum logic [1:0] {TRIG_SW, TRIG_EXT, TRIG_PTG} trig_src_t;
    // Result output formats.
    typedef enum logic [1:0] {FMT_UINT, FMT_SINT, FMT_UFRAC, FMT_SFRAC} fmt_t;
endpackage

// File: hdl/regbus_if.sv
/*
 * Register access strobes between the AXI4-Lite slave and the core.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface regbus_if;
    logic wrEn; // One-cycle write strobe.
    logic [7:0] wrAddr; // Write byte address.
    logic [31:0] wrData; // Write data.
    logic [3:0] wrStrb; // Write byte enables.
    logic wrHit; // Write address is mapped.
    logic [7:0] rdAddr; // Read byte address.
    logic [31:0] rdData; // Read data for rdAddr.
    logic rdHit; // Read address is mapped.
    modport bus (output wrEn, wrAddr, wrData, wrStrb, rdAddr, input wrHit, rdData, rdHit);
    modport core (input wrEn, wrAddr, wrData, wrStrb, rdAddr, output wrHit, rdData, rdHit);
endinterface

// File: hdl/axil_slave.sv
/*
 * AXI4-Lite slave turning bus transfers into register strobes.
 * Assumes one outstanding write and one outstanding read at a time.
 */
`timescale 1ns/1ps
module axil_slave (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    regbus_if.bus rb
);
    logic awHeld; // Write address captured.
    logic wHeld; // Write data captured.
    // Address and data are taken in either order and held until both are in.
    assign awready = !awHeld;
    assign wready = !wHeld;
    assign arready = !rvalid;
    assign rb.wrEn = awHeld && wHeld && !bvalid;
    assign rb.rdAddr = araddr;

    // Write channel capture and response; unmapped writes answer SLVERR.
    always_ff @(posedge clk) begin
        if (srst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            rb.wrAddr <= 8'h00;
            rb.wrData <= 32'h0;
            rb.wrStrb <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awHeld <= 1'b1;
                rb.wrAddr <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld <= 1'b1;
                rb.wrData <= wdata;
                rb.wrStrb <= wstrb;
            end
            if (rb.wrEn) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                bvalid <= 1'b1;
                bresp <= rb.wrHit ? 2'h0 : 2'h2;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read channel: data is latched at the address handshake.
    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= 2'h0;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rb.rdHit ? rb.rdData : 32'h0;
            rresp <= rb.rdHit ? 2'h0 : 2'h2;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule // axil_slave

// File: hdl/upper_channel_router.sv
/*
 * Source selection of sampling channels 1 to 3.
 * Assumes the select bit arrives already masked in 12-bit mode.
 */
`timescale 1ns/1ps
module upper_channel_router
    import adc_sel_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic muxaSel,
    input wire logic [2:0] opampModeEnable,
    output src_t ch1Src,
    output src_t ch2Src,
    output src_t ch3Src
);
    // Op amp output wins over the shared pin when that op amp is in use.
    function automatic src_t pick(input logic useOa, input logic [3:0] oaIdx, input logic [3:0] pin);
        // Typed patterns, because an untyped pattern has no type to take inside a conditional.
        pick = useOa ? src_t'{opamp: 1'b1, idx: oaIdx} : src_t'{opamp: 1'b0, idx: pin};
    endfunction

    src_t next_ch1; // Channel 1 source.
    src_t next_ch2; // Channel 2 source.
    src_t next_ch3; // Channel 3 source.
    // Select 1 gives op amps 1/2/3 or pins 3/0/6; select 0 gives op amp 2 or pin 0, pins 1 and 2.
    assign next_ch1 = muxaSel ? pick(opampModeEnable[0], 4'h1, 4'h3) : pick(opampModeEnable[1], 4'h2, 4'h0);
    assign next_ch2 = muxaSel ? pick(opampModeEnable[1], 4'h2, 4'h0) : src_t'{opamp: 1'b0, idx: 4'h1};
    assign next_ch3 = muxaSel ? pick(opampModeEnable[2], 4'h3, 4'h6) : src_t'{opamp: 1'b0, idx: 4'h2};

    // Registered so the analog switch controls never glitch.
    always_ff @(posedge clk) begin
        if (srst) begin
            ch1Src <= '{opamp: 1'b0, idx: 4'h0};
            ch2Src <= '{opamp: 1'b0, idx: 4'h1};
            ch3Src <= '{opamp: 1'b0, idx: 4'h2};
        end else begin
            ch1Src <= next_ch1;
            ch2Src <= next_ch2;
            ch3Src <= next_ch3;
        end
    end
endmodule // upper_channel_router

// File: hdl/adc_resolution_channel_select.sv
/*
 * Resolution, input selection, trigger and result formatting control of a
 * successive-approximation converter, with an AXI4-Lite register port.
 * Assumes the conversion core answers each start with one result per
 * sampling channel on the same clock, and trigger pins are asynchronous.
 */
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "adc_sel_cfg.svh"

module adc_resolution_channel_select
    import adc_sel_pkg::*;
#(
    parameter int PIN_COUNT = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic extTrigIn,
    input wire logic ptgTrigIn,
    input wire logic [3:0] ptgChannel,
    input wire logic resultValid,
    input wire logic [1:0] resultCh,
    input wire logic [11:0] resultRaw,
    output logic convStart,
    output logic [3:0] sampleEnable,
    output logic [3:0] ch0Pin,
    output logic [4:0] ch1Source,
    output logic [4:0] ch2Source,
    output logic [4:0] ch3Source,
    output logic [15:0] availPins,
    output logic resolution12
);
    // The pin count can never exceed the sixteen-input multiplexer.
    if (PIN_COUNT < 1 || PIN_COUNT > 16) begin : g_bad_count
        $error("PIN_COUNT must be 1 to 16");
    end

    // Minimum spacing between starts, rounded up from the rate ceiling.
    localparam int GAP10 = (`CLK_KHZ + `RATE10_KSPS - 1) / `RATE10_KSPS;
    localparam int GAP12 = (`CLK_KHZ + `RATE12_KSPS - 1) / `RATE12_KSPS;
    localparam logic [15:0] PRESENT = 16'(17'h0ffff >> (16 - PIN_COUNT));

    // Byte-lane merge for the 16-bit registers.
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Converts a left-aligned raw sample into the chosen output format.
    function automatic logic [15:0] fmtResult(input logic [11:0] raw, input logic r12, input fmt_t f);
        logic [15:0] left;
        left = r12 ? {raw, 4'h0} : {raw[11:2], 6'h0};
        unique case (f)
            FMT_UINT: fmtResult = r12 ? {4'h0, raw} : {6'h0, raw[11:2]};
            FMT_SINT: fmtResult = r12 ? {{5{~raw[11]}}, raw[10:0]} : {{7{~raw[11]}}, raw[10:2]};
            FMT_UFRAC: fmtResult = left;
            FMT_SFRAC: fmtResult = {~left[15], left[14:0]};
        endcase
    endfunction

    // Next scanned pin after cur among the enabled set, wrapping round.
    function automatic logic [3:0] nextScan(input logic [3:0] cur, input logic [15:0] m);
        logic [3:0] idx;
        nextScan = cur;
        for (int j = 16; j >= 1; j--) begin
            idx = 4'(cur + 4'(j));
            if (m[idx]) begin
                nextScan = idx;
            end
        end
    endfunction

    regbus_if rb ();

    axil_slave u_bus (
        .clk(clk), .srst(srst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .rb(rb)
    );

    logic adcOn; // Converter enabled.
    logic [1:0] fmtSel; // Result format code.
    logic [1:0] trigSrc; // Trigger source code.
    logic scanEn; // Automatic channel scan.
    logic simul; // Simultaneous sampling of all four channels, in 10-bit mode only.
    logic ptgCtl; // Trigger generator picks the channel.
    logic upperChannelMuxaSelect; // Stored channel 1-3 select.
    logic [2:0] opampModeEnable; // Op amps in use.
    logic [2:0] cmpEnable; // Comparators in use.
    logic vrefEnable; // External reference in use.
    logic [3:0] ch0Sel; // Software channel 0 pin.
    logic [15:0] scanMask; // Pins in the scan.
    logic [3:0] scanPtr; // Current scanned pin.
    logic pinErr; // Sticky: trigger aimed at an unusable pin.
    conv_state_t state; // Sequencer state.
    logic [8:0] gapCnt; // Cycles left before the next start.
    logic [2:0] pending; // Results still owed by the core.
    logic [15:0] results [4]; // Formatted result per channel.
    logic [1:0] extSync; // Pin synchroniser; bit 0 feeds bit 1 only.
    logic [1:0] ptgSync; // Pin synchroniser; bit 0 feeds bit 1 only.
    logic extLast; // Previous synchronised level.
    logic ptgLast; // Previous synchronised level.
    src_t r1; // Router channel 1 output.
    src_t r2; // Router channel 2 output.
    src_t r3; // Router channel 3 output.

    // Write decode.
    wire wrCtrl = rb.wrEn && rb.wrAddr == `OFF_CTRL;
    wire wrUpper = rb.wrEn && rb.wrAddr == `OFF_UPPER;
    wire wrCh0 = rb.wrEn && rb.wrAddr == `OFF_CH0;
    wire wrScan = rb.wrEn && rb.wrAddr == `OFF_SCAN;
    wire wrShare = rb.wrEn && rb.wrAddr == `OFF_SHARE;
    wire wrStat = rb.wrEn && rb.wrAddr == `OFF_STAT;
    wire [15:0] ctrlRd = {7'h0, ptgCtl, simul, scanEn, trigSrc, fmtSel, resolution12, adcOn};
    wire [15:0] ctrlNew = merge(ctrlRd, rb.wrData, rb.wrStrb);
    wire [15:0] shareRd = {7'h0, vrefEnable, 1'b0, cmpEnable, 1'b0, opampModeEnable};
    wire [15:0] shareNew = merge(shareRd, rb.wrData, rb.wrStrb);
    wire [15:0] ch0New = merge({12'h0, ch0Sel}, rb.wrData, rb.wrStrb);
    wire swTrig = wrCtrl && rb.wrStrb[1] && rb.wrData[`CTRL_SWTRIG];

    // Pins claimed by op amps, comparators or the reference leave the pool.
    wire [2:0] sharedUse = opampModeEnable | cmpEnable;
    wire [15:0] sharedPins = {9'h0, sharedUse[2], 2'h0, sharedUse[0], 2'h0, sharedUse[1]};
    wire [15:0] availNow = PRESENT & ~sharedPins & ~(vrefEnable ? `VREF_PINS : 16'h0);

    // Channel 0 pin from scan, trigger generator or software.
    wire [3:0] pinSel = scanEn ? scanPtr : (ptgCtl ? ptgChannel : ch0Sel);
    wire pinOk = availNow[pinSel];
    wire trigSel = (trigSrc == TRIG_SW) ? swTrig :
                   (trigSrc == TRIG_EXT) ? (extSync[1] && !extLast) :
                   (trigSrc == TRIG_PTG) ? (ptgSync[1] && !ptgLast) : 1'b0;
    // Low-power CPU states are deliberately not an input here, so nothing pauses it.
    wire ready = adcOn && state == IDLE && gapCnt == 9'h0;
    wire accept = ready && trigSel && pinOk;
    wire refuse = ready && trigSel && !pinOk;
    wire wide = simul && !resolution12;
    wire [3:0] next_sample = wide ? 4'hf : 4'h1;
    wire [8:0] next_gap = resolution12 ? 9'(GAP12 - 1) : 9'(GAP10 - 1);
    wire muxaEff = upperChannelMuxaSelect && !resolution12;
    wire lastResult = resultValid && pending == 3'h1;

    // Read decode.
    wire [15:0] statRd = {8'h0, sampleEnable, 1'b0, pinErr, resolution12, state == BUSY};
    wire resRd = rb.rdAddr[7:4] == `OFF_RES_BASE && rb.rdAddr[1:0] == 2'h0;
    wire [15:0] rd16 = (rb.rdAddr == `OFF_CTRL) ? ctrlRd :
                       (rb.rdAddr == `OFF_UPPER) ? {15'h0, muxaEff} :
                       (rb.rdAddr == `OFF_CH0) ? {12'h0, ch0Sel} :
                       (rb.rdAddr == `OFF_SCAN) ? scanMask :
                       (rb.rdAddr == `OFF_SHARE) ? shareRd :
                       (rb.rdAddr == `OFF_STAT) ? statRd :
                       (rb.rdAddr == `OFF_AVAIL) ? availPins :
                       resRd ? results[rb.rdAddr[3:2]] : 16'h0;
    assign rb.rdData = {16'h0, rd16};
    assign rb.rdHit = rb.rdAddr[1:0] == 2'h0 && (rb.rdAddr <= `OFF_AVAIL || resRd);
    assign rb.wrHit = rb.wrAddr[1:0] == 2'h0 && rb.wrAddr <= `OFF_STAT;

    // Control register; resolution holds while the converter stays on.
    always_ff @(posedge clk) begin
        if (srst) begin
            adcOn <= 1'b0;
            resolution12 <= 1'b0;
            {ptgCtl, simul, scanEn, trigSrc, fmtSel} <= 7'h00;
        end else if (wrCtrl) begin
            adcOn <= ctrlNew[`CTRL_ON];
            if (!adcOn) begin
                resolution12 <= ctrlNew[`CTRL_RES12];
            end
            {ptgCtl, simul, scanEn, trigSrc, fmtSel} <= ctrlNew[`CTRL_PTG:`CTRL_FMT];
        end
    end

    // Selection and sharing registers.
    always_ff @(posedge clk) begin
        if (srst) begin
            upperChannelMuxaSelect <= 1'b0;
            ch0Sel <= `RST_CH0;
            scanMask <= `RST_SCAN;
            {vrefEnable, cmpEnable, opampModeEnable} <= 7'h00;
        end else begin
            if (wrUpper && rb.wrStrb[0]) begin
                upperChannelMuxaSelect <= rb.wrData[0];
            end
            if (wrCh0) begin
                ch0Sel <= ch0New[3:0];
            end
            if (wrScan) begin
                scanMask <= merge(scanMask, rb.wrData, rb.wrStrb);
            end
            if (wrShare) begin
                {vrefEnable, cmpEnable, opampModeEnable} <=
                    {shareNew[`SHARE_VREF], shareNew[`SHARE_CMP+:3], shareNew[`SHARE_OPAMP+:3]};
            end
        end
    end

    // Trigger pin synchronisers and edge history.
    always_ff @(posedge clk) begin
        if (srst) begin
            extSync <= 2'h0;
            ptgSync <= 2'h0;
            extLast <= 1'b0;
            ptgLast <= 1'b0;
        end else begin
            extSync <= {extSync[0], extTrigIn};
            ptgSync <= {ptgSync[0], ptgTrigIn};
            extLast <= extSync[1];
            ptgLast <= ptgSync[1];
        end
    end

    // Sticky pin error: a new refusal wins over a write-one clear.
    always_ff @(posedge clk) begin
        if (srst) begin
            pinErr <= 1'b0;
        end else if (refuse) begin
            pinErr <= 1'b1;
        end else if (wrStat && rb.wrStrb[0] && rb.wrData[2]) begin
            pinErr <= 1'b0;
        end
    end

    // Sequencer: start, wait for each channel's result, enforce the rate gap.
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= IDLE;
            gapCnt <= 9'h0;
            pending <= 3'h0;
            convStart <= 1'b0;
            sampleEnable <= 4'h0;
            ch0Pin <= 4'h0;
            scanPtr <= 4'h0;
        end else begin
            convStart <= accept;
            gapCnt <= accept ? next_gap : (gapCnt != 9'h0 ? gapCnt - 9'h1 : 9'h0);
            if (accept) begin
                state <= BUSY;
                pending <= wide ? 3'h4 : 3'h1;
                sampleEnable <= next_sample;
                ch0Pin <= pinSel;
                scanPtr <= nextScan(scanPtr, scanMask & availNow);
            end else if (!adcOn || (state == BUSY && lastResult)) begin
                state <= IDLE;
                pending <= 3'h0;
                sampleEnable <= 4'h0;
            end else if (state == BUSY && resultValid) begin
                pending <= pending - 3'h1;
            end
        end
    end

    // Result store, formatted as it arrives.
    always_ff @(posedge clk) begin
        if (srst) begin
            results <= '{default: 16'h0};
        end else if (resultValid && state == BUSY) begin
            results[resultCh] <= fmtResult(resultRaw, resolution12, fmt_t'(fmtSel));
        end
    end

    // Registered availability view for software and the pad logic.
    always_ff @(posedge clk) begin
        if (srst) begin
            availPins <= 16'h0;
        end else begin
            availPins <= availNow;
        end
    end

    upper_channel_router u_route (
        .clk(clk), .srst(srst),
        .muxaSel(muxaEff),
        .opampModeEnable(opampModeEnable),
        .ch1Src(r1), .ch2Src(r2), .ch3Src(r3)
    );
    assign ch1Source = r1;
    assign ch2Source = r2;
    assign ch3Source = r3;

    // Helper: cycles since the last start, saturating.
    logic [8:0] sinceStart;
    logic started;
    always_ff @(posedge clk) begin
        if (srst) begin
            sinceStart <= 9'h0;
            started <= 1'b0;
        end else if (convStart) begin
            sinceStart <= 9'h1;
            started <= 1'b1;
        end else if (sinceStart != 9'h1ff) begin
            sinceStart <= sinceStart + 9'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    single_sh_a: assert property (resolution12 |-> sampleEnable[3:1] == 3'h0)
        else $error("several channels sampling in 12-bit mode");
    quad_sh_a: assert property (accept && wide |=> sampleEnable == 4'hf && convStart)
        else $error("simultaneous start did not enable four channels");
    res_lock_a: assert property (adcOn && $past(adcOn) |-> $stable(resolution12))
        else $error("resolution changed while enabled");
    rate_gap_a: assert property (convStart && started |-> sinceStart >= (resolution12 ? GAP12 : GAP10))
        else $error("conversion start too soon");
    shared_pin_a: assert property (opampModeEnable[0] || cmpEnable[0] |=> !availPins[3])
        else $error("shared pin still offered");
    sample_mux_a_zero_a: assert property (resolution12 |-> rd16 == 16'h0 || rb.rdAddr != `OFF_UPPER)
        else $error("upper select reads nonzero in 12-bit mode");
    route_oa_a: assert property (muxaEff && opampModeEnable[0] ##1 $stable(opampModeEnable) && muxaEff
        |-> r1 == src_t'{opamp: 1'b1, idx: 4'h1})
        else $error("op amp 1 not routed to channel 1");
    route_pin_a: assert property (!muxaEff ##1 !muxaEff |-> r2 == src_t'{opamp: 1'b0, idx: 4'h1})
        else $error("channel 2 not on pin 1");
    pin_range_a: assert property (convStart |-> availPins[ch0Pin] && ch0Pin < PIN_COUNT)
        else $error("conversion on missing pin");
    uint_fmt_a: assert property (resultValid && state == BUSY && fmtSel == 2'h0 && resolution12
        |=> results[$past(resultCh)] == {4'h0, $past(resultRaw)})
        else $error("unsigned integer result wrong");
    start_cover_c: cover property (convStart && resolution12);
    quad_cover_c: cover property (convStart && sampleEnable == 4'hf);
    scan_cover_c: cover property (convStart && scanEn ##[1:500] convStart);
    refuse_cover_c: cover property (refuse);
endmodule // adc_resolution_channel_select

// File: verif/conv_core_model.sv
/* Core stand-in; expects start and enables from the block. */
`timescale 1ns/1ps
module conv_core_model (
    input wire logic clk,
    input wire logic convStart,
    input wire logic [3:0] sampleEnable,
    output logic resultValid,
    output logic [1:0] resultCh,
    output logic [11:0] resultRaw
);
    initial begin
        {resultValid, resultCh, resultRaw} = '0;
        forever @(posedge clk) if (convStart) begin
            repeat ($urandom_range(1, 40)) @(posedge clk);
            for (int i = 0; i < 4; i++) if (sampleEnable[i]) begin
                {resultValid, resultCh, resultRaw} <= {1'b1, 2'(i), 12'($urandom)};
                @(posedge clk);
            end
            {resultValid, resultRaw} <= {1'b0, ~resultRaw};
        end
    end
endmodule // conv_core_model

// File: verif/tb.sv
/* Bench of the converter control; uses the core stand-in. */
`timescale 1ns/1ps
module tb;
    logic clk = 0, srst, awvalid, wvalid, bready, arvalid, rready, extTrigIn, ptgTrigIn;
    logic awready, wready, bvalid, arready, rvalid, resultValid, convStart, resolution12;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb, ptgChannel, sampleEnable, ch0Pin, lastEn;
    logic [1:0] bresp, rresp, resultCh, wr;
    logic [11:0] resultRaw;
    logic [4:0] ch1Source, ch2Source, ch3Source;
    logic [15:0] availPins;
    int num_errors, n_tests, starts, r, s, f;
    int q[$]; // Raw results in arrival order, channel in bits 13:12.
    adc_resolution_channel_select u_adc_resolution_channel_select (.*);
    conv_core_model u_conv_core_model (.*);
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) if (convStart) {starts, lastEn} <= {starts + 1, sampleEnable};
    always @(posedge clk) if (resultValid) q.push_back({resultCh, resultRaw});
    // Reference format: signed subtracts half scale, fractional left-aligns in 16 bits.
    function automatic int fmtExp(int raw, int r12, int fm);
        int v;
        v = (r12 ? raw : raw >> 2) - (fm[0] ? 1 << (r12 ? 11 : 9) : 0);
        return (fm[1] ? v << (r12 ? 4 : 6) : v) & 32'hffff;
    endfunction
    task automatic chk(string n, logic [39:0] seen, exp);
        n_tests++;
        num_errors += int'(seen !== exp);
        if (seen !== exp) $display("Error %s expected %h seen %h", n, exp, seen);
    endtask
    // Each valid drops once taken.
    task automatic axi(bit w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        {awaddr, araddr, wdata, wstrb} <= {a, a, d, 4'hf};
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            {wr, rd} = {w ? bresp : rresp, rdata};
        end while (!(w ? bvalid : rvalid));
        {bready, rready} <= 2'b00;
    endtask
    task automatic final_report(int hang);
        num_errors += hang;
        $display("%0d checks, %0d mismatches", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial #100us final_report(1);
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, extTrigIn, ptgTrigIn, srst} = 8'h01;
        {awaddr, araddr, wdata, wstrb, ptgChannel} = '0;
        void'($urandom(32'h54e9));
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        axi(0, 8'h00, 0);
        axi(1, 8'h40, 0);
        chk("reset", {wr, rd, resolution12}, 35'h400000000);
        $display("test reset done");
        repeat (8) begin
            r = $urandom & 32'h377;
            axi(1, 8'h10, r & 32'h177);
            axi(1, 8'h04, r[9]);
            repeat (2) @(posedge clk);
            s = r[9] ? {r[0] ? 5'h11 : 5'h3, r[1] ? 5'h12 : 5'h0, r[2] ? 5'h13 : 5'h6} : {r[1] ? 5'h12 : 5'h0, 10'h22};
            chk("route", {ch1Source, ch2Source, ch3Source}, s);
            s = ~((r[8] ? 3 : 0) | (r[0] | r[4]) << 3 | (r[1] | r[5]) | (r[2] | r[6]) << 6);
            chk("avail", availPins, s[15:0]);
        end
        $display("test routing done");
        axi(1, 8'h10, 0);
        for (int m = 0; m < 2; m++) begin
            f = m ? 0 : 1 + $urandom % 3;
            r = $urandom & 15;
            axi(1, 8'h08, r);
            axi(1, 8'h00, m << 1);
            axi(1, 8'h00, 32'h81 | m << 1 | f << 2);
            repeat (450) @(posedge clk);
            axi(1, 8'h00, 32'h281 | m << 1 | f << 2);
            repeat (2) @(posedge clk);
            while (sampleEnable !== 4'h0) @(posedge clk);
            chk("mode", resolution12, m);
            chk("start", {lastEn, starts, ch0Pin}, {m ? 4'h1 : 4'hf, 32'(m + 1), r[3:0]});
            chk("count", q.size(), m ? 1 : 4);
            while (q.size() > 0) begin
                s = q.pop_front();
                axi(0, {4'h2, s[13:12], 2'h0}, 0);
                chk("result", rd, fmtExp(s[11:0], m, f));
            end
        end
        axi(1, 8'h08, 6);
        axi(1, 8'h10, 32'h40);
        repeat (400) @(posedge clk);
        axi(1, 8'h00, 32'h203);
        axi(0, 8'h14, 0);
        chk("refuse", {rd[2:0], starts}, {3'h6, 32'd2});
        for (int t = 1; t < 3; t++) begin
            repeat (400) @(posedge clk);
            axi(1, 8'h00, 32'h103 | t << 4);
            {extTrigIn, ptgTrigIn, ptgChannel} <= {t == 1, t == 2, 4'h5};
            repeat (8) @(posedge clk);
            {extTrigIn, ptgTrigIn} <= 2'b00;
            chk("trigger", {starts, ch0Pin}, {32'(t + 2), 4'h5});
        end
        axi(1, 8'h04, 1);
        axi(0, 8'h04, 0);
        chk("upper", {wr, rd}, 0);
        axi(1, 8'h00, 1);
        axi(0, 8'h00, 0);
        chk("hold", {rd[1:0], resolution12}, 3'h7);
        $display("test conversion done");
        final_report(0);
    end
endmodule // tb
